/* File: rtl/pdmc_ctrl.sv */
// Power-down mode controller: sleep, software standby, hardware standby, reset.
// Assumes pins arrive synchronous to i_ref_clk and the CPU pulses sleep execution.
// Overview of operation
// - A sleep instruction in execution with the select bit clear enters sleep and halts the CPU.
// - Sleep keeps every CPU register unchanged.
// - Sleep keeps the clock and all modules running.
// - A sleep instruction with the select bit set enters software standby, stopping and reinitialising modules.
// - A low standby pin enters hardware standby from anywhere, clearing CPU registers and floating ports.
// - Sleep ends on an accepted interrupt, a low reset pin or a low standby pin.
// - An interrupt ending sleep starts either CPU interrupt handling or a transfer, as assigned.
// - After such a transfer the CPU resumes after the sleep instruction unless the count is zero.
// - An interrupt at or below the CPU mask level stays pending and does not end sleep.
// - A module interrupt disabled at its module makes no request and does not wake.
// - A low reset pin during sleep goes straight to reset.
// - A low standby pin during sleep goes straight to hardware standby.
// - Software standby ends only on the nonmaskable interrupt, a low reset pin or a low standby pin.
// - The select bit cannot be set while the watchdog is enabled.
// - Hardware standby ends with standby high and reset low, then reset release runs the reset sequence.
module pdmc_ctrl #(
   parameter int N = pdmc_pkg::PDMC_SRC_N
) (
   // Clock and reset
   input  wire logic                                  i_ref_clk,
   input  wire logic                                  i_rst_n,
   // Register port
   input  wire pdmc_pkg::pdmc_bus_type                i_bus,
   output logic [7:0]                                 o_rdata,
   // Pins
   input  wire logic                                  i_reset_pin_n,
   input  wire logic                                  i_hw_standby_pin_n,
   input  wire logic                                  i_nmi,
   // CPU, watchdog and transfer controller
   input  wire logic                                  i_sleep_exec,
   input  wire logic                                  i_watchdog_enable_bit,
   input  wire logic                                  i_wdt_overflow,
   input  wire logic [pdmc_pkg::PDMC_LVL_W-1:0]       i_cpu_status_mask,
   input  wire logic                                  i_xfer_done,
   input  wire logic                                  i_xfer_count_zero,
   // Interrupt sources
   input  wire logic [N-1:0]                          i_irq_req,
   input  wire logic [N-1:0]                          i_irq_en,
   input  wire logic [N-1:0][pdmc_pkg::PDMC_LVL_W-1:0] i_irq_level,
   input  wire logic [N-1:0]                          i_irq_to_xfer,
   // Mode, gating and select bit
   output pdmc_pkg::pdmc_mode_type                    o_mode,
   output pdmc_pkg::pdmc_gate_type                    o_gate,
   output logic                                       o_standby_select_bit,
   // Start pulses and wake source
   output logic                                       o_int_start,
   output logic                                       o_nmi_start,
   output logic                                       o_xfer_start,
   output logic                                       o_resume,
   output logic                                       o_reset_seq,
   output logic [pdmc_pkg::PDMC_SRC_W-1:0]            o_wake_src
);
   import pdmc_pkg::*;

   pdmc_state_type        st_q;
   pdmc_state_type        st_d;
   logic                  wake_hit;
   logic [PDMC_SRC_W-1:0] wake_idx;
   logic                  wake_xfer;
   logic                  sbctl_we;

   pdmc_wake_arb #(
      .N (N)
   ) u_arb (
      .i_req     (i_irq_req),
      .i_en      (i_irq_en),
      .i_level   (i_irq_level),
      .i_to_xfer (i_irq_to_xfer),
      .i_mask    (i_cpu_status_mask),
      .o_hit     (wake_hit),
      .o_idx     (wake_idx),
      .o_xfer    (wake_xfer)
   );

   assign sbctl_we = i_bus.we & (i_bus.addr == PDMC_SBCTL_ADDR);

   always_comb begin
      st_d            = st_q;
      st_d.int_start  = 1'h0;
      st_d.nmi_start  = 1'h0;
      st_d.xfer_start = 1'h0;
      st_d.resume     = 1'h0;
      st_d.reset_seq  = 1'h0;

      // Select bit: clearing always allowed, setting refused under watchdog
      if (sbctl_we) begin
         st_d.sel = i_bus.wdata[PDMC_SEL_POS] & ~i_watchdog_enable_bit;
      end

      // Read data stand one cycle after the strobe
      if (i_bus.re && i_bus.addr == PDMC_SBCTL_ADDR) begin
         st_d.rdata = PDMC_SBCTL_RSV | {st_q.sel, 7'h00};
      end else if (i_bus.re && i_bus.addr == PDMC_STAT_ADDR) begin
         st_d.rdata = 8'(st_q.mode);
      end else begin
         st_d.rdata = PDMC_RD_NONE;
      end

      if (!i_hw_standby_pin_n) begin
         st_d.mode = PDMC_HW_STANDBY;
         st_d.sel  = 1'h0;
      end else begin
         case (st_q.mode)
            PDMC_HW_STANDBY: begin
               // Leave only once reset is seen low with standby high
               if (!i_reset_pin_n) begin
                  st_d.mode = PDMC_RESET;
               end
            end
            PDMC_RESET: begin
               st_d.sel = 1'h0;
               if (i_reset_pin_n) begin
                  st_d.mode      = PDMC_EXEC;
                  st_d.reset_seq = 1'h1;
               end
            end
            PDMC_EXEC: begin
               if (!i_reset_pin_n) begin
                  st_d.mode = PDMC_RESET;
               end else if (i_sleep_exec) begin
                  st_d.mode = st_q.sel ? PDMC_SW_STANDBY : PDMC_SLEEP;
               end
            end
            PDMC_SLEEP: begin
               if (!i_reset_pin_n) begin
                  st_d.mode = PDMC_RESET;
               end else if (i_nmi) begin
                  st_d.mode      = PDMC_EXEC;
                  st_d.nmi_start = 1'h1;
               end else if (wake_hit && wake_xfer) begin
                  st_d.mode       = PDMC_XFER;
                  st_d.xfer_start = 1'h1;
                  st_d.src        = wake_idx;
               end else if (wake_hit) begin
                  st_d.mode      = PDMC_EXEC;
                  st_d.int_start = 1'h1;
                  st_d.src       = wake_idx;
               end
            end
            PDMC_XFER: begin
               if (!i_reset_pin_n) begin
                  st_d.mode = PDMC_RESET;
               end else if (i_xfer_done) begin
                  st_d.mode      = PDMC_EXEC;
                  st_d.resume    = ~i_xfer_count_zero;
                  st_d.int_start = i_xfer_count_zero;
               end
            end
            PDMC_SW_STANDBY: begin
               if (!i_reset_pin_n) begin
                  st_d.mode = PDMC_RESET;
               end else if (i_nmi) begin
                  st_d.mode = PDMC_SW_WAKE;
               end
            end
            PDMC_SW_WAKE: begin
               // Only the watchdog is clocked until it overflows
               if (!i_reset_pin_n) begin
                  st_d.mode = PDMC_RESET;
               end else if (i_wdt_overflow) begin
                  st_d.mode      = PDMC_EXEC;
                  st_d.nmi_start = 1'h1;
                  st_d.sel       = 1'h0;
               end
            end
            default: begin
               st_d.mode = PDMC_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         st_q <= '{mode: PDMC_RESET, sel: 1'h0, int_start: 1'h0, nmi_start: 1'h0,
                   xfer_start: 1'h0, resume: 1'h0, reset_seq: 1'h0, src: '0, rdata: '0};
      end else begin
         st_q <= st_d;
      end
   end

   assign o_mode               = st_q.mode;
   assign o_gate               = pdmc_gates(st_q.mode);
   assign o_standby_select_bit = st_q.sel;
   assign o_rdata              = st_q.rdata;
   assign o_int_start          = st_q.int_start;
   assign o_nmi_start          = st_q.nmi_start;
   assign o_xfer_start         = st_q.xfer_start;
   assign o_resume             = st_q.resume;
   assign o_reset_seq          = st_q.reset_seq;
   assign o_wake_src           = st_q.src;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   logic pins_up;
   assign pins_up = i_reset_pin_n & i_hw_standby_pin_n;

   sequence s_hw_held;
      o_mode == PDMC_HW_STANDBY && i_hw_standby_pin_n && !i_reset_pin_n;
   endsequence

   sequence s_reset_release;
      o_mode == PDMC_RESET && pins_up;
   endsequence

   // Sleep entry and what sleep keeps
   sleep_entry_a: assert property (o_mode == PDMC_EXEC && pins_up && i_sleep_exec && !o_standby_select_bit
      |=> o_mode == PDMC_SLEEP && o_gate.cpu_halt) else $error("sleep not entered");

   exec_run_a: assert property (o_mode == PDMC_EXEC |-> !o_gate.cpu_halt && o_gate.clock_run)
      else $error("cpu halted in execution");

   reg_hold_a: assert property (o_mode == PDMC_SLEEP |-> o_gate.reg_hold && !o_gate.reg_clear)
      else $error("registers not held in sleep");

   sleep_run_a: assert property (o_mode == PDMC_SLEEP |-> o_gate.clock_run && o_gate.module_run)
      else $error("clock or modules stopped in sleep");

   // Software standby entry and gating
   swstby_entry_a: assert property (o_mode == PDMC_EXEC && pins_up && i_sleep_exec && o_standby_select_bit
      |=> o_mode == PDMC_SW_STANDBY && !o_gate.clock_run && o_gate.module_init)
      else $error("no sw standby");

   swstby_gate_a: assert property (o_mode == PDMC_SW_STANDBY
      |-> o_gate.cpu_halt && !o_gate.clock_run && !o_gate.module_run && o_gate.reg_hold)
      else $error("sw standby gating wrong");

   // Hardware standby entry and gating
   hw_entry_a: assert property (!i_hw_standby_pin_n |=> o_mode == PDMC_HW_STANDBY && o_gate.ports_float
      && o_gate.reg_clear && !o_standby_select_bit) else $error("hw standby missed");

   hw_gate_a: assert property (o_mode == PDMC_HW_STANDBY
      |-> o_gate.cpu_halt && !o_gate.clock_run && !o_gate.reg_hold)
      else $error("hw standby gating wrong");

   hw_over_a: assert property (!i_hw_standby_pin_n && !i_reset_pin_n |=> o_mode == PDMC_HW_STANDBY)
      else $error("standby pin lost to reset");

   // Wake from sleep
   nmi_wake_a: assert property (o_mode == PDMC_SLEEP && pins_up && i_nmi
      |=> o_mode == PDMC_EXEC && o_nmi_start) else $error("nmi did not end sleep");

   mask_pend_a: assert property (o_mode == PDMC_SLEEP && pins_up && !i_nmi && !wake_hit
      |=> o_mode == PDMC_SLEEP && !o_int_start) else $error("sleep left without wake");

   wake_path_a: assert property (o_mode == PDMC_SLEEP && pins_up && !i_nmi && wake_hit
      |=> (o_xfer_start ^ o_int_start) && o_wake_src == $past(wake_idx)) else $error("bad wake start");

   reset_exit_a: assert property (o_mode == PDMC_SLEEP && i_hw_standby_pin_n && !i_reset_pin_n
      |=> o_mode == PDMC_RESET) else $error("reset in sleep missed");

   sleep_hw_a: assert property (o_mode == PDMC_SLEEP && !i_hw_standby_pin_n
      |=> o_mode == PDMC_HW_STANDBY) else $error("standby in sleep missed");

   // Transfer completion
   xfer_end_a: assert property (o_mode == PDMC_XFER && pins_up && i_xfer_done
      |=> o_mode == PDMC_EXEC && o_resume == !$past(i_xfer_count_zero)) else $error("bad transfer end");

   xfer_zero_a: assert property (o_mode == PDMC_XFER && pins_up && i_xfer_done && i_xfer_count_zero
      |=> o_int_start && !o_resume) else $error("zero count resumed");

   xfer_wait_a: assert property (o_mode == PDMC_XFER && pins_up && !i_xfer_done
      |=> o_mode == PDMC_XFER) else $error("transfer left early");

   // Software standby exit
   swstby_hold_a: assert property (o_mode == PDMC_SW_STANDBY && pins_up && !i_nmi
      |=> o_mode == PDMC_SW_STANDBY) else $error("sw standby left");

   swstby_nmi_a: assert property (o_mode == PDMC_SW_STANDBY && pins_up && i_nmi
      |=> o_mode == PDMC_SW_WAKE) else $error("nmi did not end sw standby");

   swwake_exit_a: assert property (o_mode == PDMC_SW_WAKE && pins_up && i_wdt_overflow
      |=> o_mode == PDMC_EXEC && o_nmi_start && !o_standby_select_bit)
      else $error("bad sw standby recovery");

   // Select bit writes
   sel_refuse_a: assert property (sbctl_we && i_watchdog_enable_bit && !o_standby_select_bit
      |=> !o_standby_select_bit) else $error("select set under watchdog");

   sel_write_a: assert property (sbctl_we && i_bus.wdata[PDMC_SEL_POS] && !i_watchdog_enable_bit
      && o_mode == PDMC_EXEC && pins_up |=> o_standby_select_bit) else $error("select write lost");

   // Hardware standby exit
   hw_stay_a: assert property (o_mode == PDMC_HW_STANDBY && pins_up
      |=> o_mode == PDMC_HW_STANDBY) else $error("hw standby left without reset");

   reset_hold_a: assert property (o_mode == PDMC_RESET && i_hw_standby_pin_n && !i_reset_pin_n
      |=> o_mode == PDMC_RESET && !o_reset_seq) else $error("reset left early");

   hw_exit_a: assert property (s_hw_held ##1 s_reset_release |=> o_mode == PDMC_EXEC && o_reset_seq)
      else $error("hw standby exit sequence wrong");

endmodule : pdmc_ctrl

/* File: rtl/pdmc_pkg.sv */
// Package for the power-down mode controller: addresses, modes, carriers.
// Assumes one 50 MHz clock and a plain strobe register port.
package pdmc_pkg;

   // Register map (byte addresses on the plain port)
   localparam logic [15:0] PDMC_SBCTL_ADDR = 16'hff13;
   localparam logic [15:0] PDMC_STAT_ADDR  = 16'hff14;
   localparam int          PDMC_SEL_POS    = 7;
   localparam logic [7:0]  PDMC_SBCTL_RSV  = 8'h7f;
   localparam logic [7:0]  PDMC_RD_NONE    = 8'h00;

   // Wake sources
   localparam int          PDMC_SRC_N      = 8;
   localparam int          PDMC_SRC_W      = 3;
   localparam int          PDMC_LVL_W      = 3;

   typedef enum logic [2:0] {
      PDMC_EXEC,
      PDMC_SLEEP,
      PDMC_SW_STANDBY,
      PDMC_SW_WAKE,
      PDMC_XFER,
      PDMC_HW_STANDBY,
      PDMC_RESET
   } pdmc_mode_type;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } pdmc_bus_type;

   typedef struct packed {
      logic cpu_halt;
      logic clock_run;
      logic module_run;
      logic module_init;
      logic reg_hold;
      logic reg_clear;
      logic ports_float;
      logic wdt_clock_only;
   } pdmc_gate_type;

   typedef struct packed {
      pdmc_mode_type         mode;
      logic                  sel;
      logic                  int_start;
      logic                  nmi_start;
      logic                  xfer_start;
      logic                  resume;
      logic                  reset_seq;
      logic [PDMC_SRC_W-1:0] src;
      logic [7:0]            rdata;
   } pdmc_state_type;

   // Gating seen by CPU, clock and modules in each mode
   function automatic pdmc_gate_type pdmc_gates(input pdmc_mode_type m);
      pdmc_gate_type g;
      g = '0;
      case (m)
         PDMC_EXEC: begin
            g.clock_run  = 1'h1;
            g.module_run = 1'h1;
         end
         PDMC_SLEEP, PDMC_XFER: begin
            g.cpu_halt   = 1'h1;
            g.clock_run  = 1'h1;
            g.module_run = 1'h1;
            g.reg_hold   = 1'h1;
         end
         PDMC_SW_STANDBY: begin
            g.cpu_halt    = 1'h1;
            g.module_init = 1'h1;
            g.reg_hold    = 1'h1;
         end
         PDMC_SW_WAKE: begin
            g.cpu_halt       = 1'h1;
            g.module_init    = 1'h1;
            g.reg_hold       = 1'h1;
            g.wdt_clock_only = 1'h1;
         end
         PDMC_HW_STANDBY: begin
            g.cpu_halt    = 1'h1;
            g.module_init = 1'h1;
            g.reg_clear   = 1'h1;
            g.ports_float = 1'h1;
         end
         PDMC_RESET: begin
            g.cpu_halt    = 1'h1;
            g.clock_run   = 1'h1;
            g.module_init = 1'h1;
            g.reg_clear   = 1'h1;
         end
         default: begin
            g.cpu_halt = 1'h1;
         end
      endcase
      return g;
   endfunction : pdmc_gates

endpackage : pdmc_pkg

/* File: rtl/pdmc_wake_arb.sv */
// Wake arbiter: picks the lowest-numbered source that may end sleep.
// Assumes requests, enables and levels are synchronous to the clock.
module pdmc_wake_arb #(
   parameter int N = pdmc_pkg::PDMC_SRC_N
) (
   // Sources
   input  wire logic [N-1:0]                          i_req,
   input  wire logic [N-1:0]                          i_en,
   input  wire logic [N-1:0][pdmc_pkg::PDMC_LVL_W-1:0] i_level,
   input  wire logic [N-1:0]                          i_to_xfer,
   // CPU mask level
   input  wire logic [pdmc_pkg::PDMC_LVL_W-1:0]       i_mask,
   // Result
   output logic                                       o_hit,
   output logic [pdmc_pkg::PDMC_SRC_W-1:0]            o_idx,
   output logic                                       o_xfer
);
   import pdmc_pkg::*;

   logic [N-1:0] ok;

   // Disabled sources make no request; masked ones stay pending
   for (genvar k = 0; k < N; k++) begin : g_ok
      assign ok[k] = i_req[k] & i_en[k] & (i_level[k] > i_mask);
   end

   always_comb begin
      o_hit  = 1'h0;
      o_idx  = '0;
      o_xfer = 1'h0;
      for (int k = N - 1; k >= 0; k--) begin
         if (ok[k]) begin
            o_hit  = 1'h1;
            o_idx  = PDMC_SRC_W'(k);
            o_xfer = i_to_xfer[k];
         end
      end
   end

endmodule : pdmc_wake_arb

/* File: sim/pdmc_far_model.sv */
// Far-side model: transfer controller and watchdog that answer the controller.
// Assumes the bench sets the delay and the count level before each wake.
module pdmc_far_model
   import pdmc_pkg::*;
(
   // Clock and reset
   input  wire logic          i_ref_clk,
   input  wire logic          i_rst_n,
   // From controller and bench
   input  wire pdmc_mode_type i_mode,
   input  wire logic          i_xfer_start,
   input  wire logic          i_count_zero,
   input  wire logic [3:0]    i_delay,
   // To controller
   output logic               o_xfer_done,
   output logic               o_count_zero,
   output logic               o_wdt_overflow
);
   logic [3:0] cnt_q;
   logic       busy_q;
   logic       kind_q;

   // Count level is only meaningful beside done; inverted otherwise
   assign o_count_zero = o_xfer_done ? i_count_zero : ~i_count_zero;

   always_ff @(posedge i_ref_clk) begin
      o_xfer_done    <= 1'h0;
      o_wdt_overflow <= 1'h0;
      if (!i_rst_n) begin
         busy_q <= 1'h0;
         kind_q <= 1'h0;
         cnt_q  <= 4'h0;
      end else if (!busy_q && !o_wdt_overflow && (i_xfer_start || i_mode == PDMC_SW_WAKE)) begin
         busy_q <= 1'h1;
         kind_q <= i_xfer_start;
         cnt_q  <= i_delay;
      end else if (busy_q && cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
         busy_q         <= 1'h0;
         o_xfer_done    <= kind_q;
         o_wdt_overflow <= !kind_q;
      end
   end
endmodule : pdmc_far_model

/* File: sim/testbench.sv */
// Testbench for the power-down mode controller with a far-side model.
// Assumes one 50 MHz clock; inputs change 1 ns after the rising edge.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pdmc_pkg::*;

   logic clk = 1'h0, rst_n = 1'h0, res_n = 1'h1, hw_standby_pin_n_n = 1'h1, nmi = 1'h0, slp = 1'h0, wdt_en = 1'h0;
   logic cz = 1'h0, done, czo, ovf, tx;
   logic [3:0] dly = 4'h0;
   logic [2:0] mask = 3'h0, m;
   logic [7:0] req = 8'h00, en = 8'h00, to_x = 8'h00, rdata;
   logic [7:0][2:0] lvl = '0;
   pdmc_bus_type bus = '0;
   pdmc_mode_type mode;
   pdmc_gate_type gate;
   logic [4:0] pul;
   logic [2:0] src;
   logic sel;
   logic [31:0] rs = 32'h5457;
   int failures = 0, tests_run = 0, cycles = 0, idx, w;

   always #10 clk = ~clk;

   pdmc_ctrl #(.N(8)) dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .o_rdata(rdata),
      .i_reset_pin_n(res_n), .i_hw_standby_pin_n(hw_standby_pin_n_n), .i_nmi(nmi), .i_sleep_exec(slp),
      .i_watchdog_enable_bit(wdt_en), .i_wdt_overflow(ovf), .i_cpu_status_mask(mask),
      .i_xfer_done(done), .i_xfer_count_zero(czo), .i_irq_req(req), .i_irq_en(en), .i_irq_level(lvl),
      .i_irq_to_xfer(to_x), .o_mode(mode), .o_gate(gate), .o_standby_select_bit(sel),
      .o_int_start(pul[4]), .o_nmi_start(pul[3]), .o_xfer_start(pul[2]), .o_resume(pul[1]),
      .o_reset_seq(pul[0]), .o_wake_src(src));

   pdmc_far_model far_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_mode(mode), .i_xfer_start(pul[2]),
      .i_count_zero(cz), .i_delay(dly), .o_xfer_done(done), .o_count_zero(czo), .o_wdt_overflow(ovf));

   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd

   // Gating expected in each mode: halt, clock, run, init, hold, clear, float, wdt-only
   function automatic logic [7:0] exp_gate(input pdmc_mode_type g);
      case (g)
         PDMC_EXEC:             return 8'h60;
         PDMC_SLEEP, PDMC_XFER: return 8'he8;
         PDMC_SW_STANDBY:       return 8'h98;
         PDMC_SW_WAKE:          return 8'h99;
         PDMC_HW_STANDBY:       return 8'h96;
         default:               return 8'hd4;
      endcase
   endfunction : exp_gate

   task automatic wrap_up();
      if (failures == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic chk_state(input pdmc_mode_type g, input logic [4:0] p);
      check({5'h00, mode}, {5'h00, g});
      check(gate, exp_gate(g));
      check({3'h0, pul}, {3'h0, p});
   endtask : chk_state

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      bus <= '{a, d, 1'h1, 1'h0};
      step(1);
      bus <= '0;
      step(1);
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      bus <= '{a, 8'h00, 1'h0, 1'h1};
      step(1);
      bus <= '0;
      check(rdata, e);
      step(1);
   endtask : rd

   task automatic sleep_to(input pdmc_mode_type g);
      slp <= 1'h1;
      step(1);
      slp <= 1'h0;
      chk_state(g, 5'h00);
   endtask : sleep_to

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         wrap_up();
      end
   end

   initial begin
      step(12);
      chk_state(PDMC_RESET, 5'h00);
      rst_n <= 1'h1;
      step(1);
      chk_state(PDMC_EXEC, 5'h01);
      rd(PDMC_SBCTL_ADDR, 8'h7f);
      wdt_en <= 1'h1;
      wr(PDMC_SBCTL_ADDR, 8'h80);
      rd(PDMC_SBCTL_ADDR, 8'h7f);
      rd(PDMC_STAT_ADDR, 8'h00);
      rd(16'h0100, 8'h00);
      // Disabled source and a source at the mask level sit below the winner
      req[1:0] <= 2'h3;
      en[1:0]  <= 2'h2;
      lvl[0]   <= 3'h7;
      for (int k = 0; k < 6; k++) begin
         m = 3'(rnd() % 7);
         idx = 2 + int'(rnd() % 6);
         tx = 1'(rnd());
         mask <= m;
         lvl[1] <= m;
         dly <= 4'(rnd());
         cz <= k[1];
         sleep_to(PDMC_SLEEP);
         step(3);
         chk_state(PDMC_SLEEP, 5'h00);
         lvl[idx] <= 3'(m + 1 + rnd() % (7 - m));
         req[idx] <= 1'h1;
         en[idx] <= 1'h1;
         to_x[idx] <= tx;
         step(1);
         req[idx] <= 1'h0;
         to_x[idx] <= 1'h0;
         chk_state(tx ? PDMC_XFER : PDMC_EXEC, tx ? 5'h04 : 5'h10);
         check({5'h00, src}, 8'(idx));
         for (w = 0; w < 20 && mode == PDMC_XFER; w++) step(1);
         if (tx) chk_state(PDMC_EXEC, k[1] ? 5'h10 : 5'h02);
      end
      sleep_to(PDMC_SLEEP);
      nmi <= 1'h1;
      step(1);
      nmi <= 1'h0;
      chk_state(PDMC_EXEC, 5'h08);
      sleep_to(PDMC_SLEEP);
      res_n <= 1'h0;
      step(1);
      chk_state(PDMC_RESET, 5'h00);
      res_n <= 1'h1;
      step(1);
      chk_state(PDMC_EXEC, 5'h01);
      sleep_to(PDMC_SLEEP);
      hw_standby_pin_n_n <= 1'h0;
      step(1);
      chk_state(PDMC_HW_STANDBY, 5'h00);
      hw_standby_pin_n_n <= 1'h1;
      step(2);
      chk_state(PDMC_HW_STANDBY, 5'h00);
      res_n <= 1'h0;
      step(1);
      chk_state(PDMC_RESET, 5'h00);
      res_n <= 1'h1;
      step(1);
      chk_state(PDMC_EXEC, 5'h01);
      wdt_en <= 1'h0;
      wr(PDMC_SBCTL_ADDR, 8'h80);
      rd(PDMC_SBCTL_ADDR, 8'hff);
      sleep_to(PDMC_SW_STANDBY);
      lvl[7] <= 3'h7;
      req[7] <= 1'h1;
      en[7] <= 1'h1;
      step(3);
      req[7] <= 1'h0;
      chk_state(PDMC_SW_STANDBY, 5'h00);
      rd(PDMC_STAT_ADDR, 8'h02);
      nmi <= 1'h1;
      step(1);
      nmi <= 1'h0;
      chk_state(PDMC_SW_WAKE, 5'h00);
      for (w = 0; w < 20 && mode == PDMC_SW_WAKE; w++) step(1);
      chk_state(PDMC_EXEC, 5'h08);
      rd(PDMC_SBCTL_ADDR, 8'h7f);
      wr(PDMC_SBCTL_ADDR, 8'h80);
      sleep_to(PDMC_SW_STANDBY);
      res_n <= 1'h0;
      hw_standby_pin_n_n <= 1'h0;
      step(1);
      chk_state(PDMC_HW_STANDBY, 5'h00);
      hw_standby_pin_n_n <= 1'h1;
      step(1);
      chk_state(PDMC_RESET, 5'h00);
      res_n <= 1'h1;
      step(1);
      chk_state(PDMC_EXEC, 5'h01);
      rd(PDMC_SBCTL_ADDR, 8'h7f);
      wrap_up();
   end
endmodule : testbench
